// ### logic/compressor_remote_control.sv
// remote discrete control of the compressor pump and two refrigerators
// assumes i_nrst is held low while the unit powers up and releases once;
// i_fault comes from on-chip fault detection on i_clk, all other inputs are pins
`timescale 1ns/1ps
`default_nettype none

module compressor_remote_control
    import compressor_remote_pkg::*;
#(
    parameter logic [compressor_remote_pkg::TIMER_W-1:0] INIT_CYCLES      = compressor_remote_pkg::INIT_CYCLES,
    parameter logic [compressor_remote_pkg::TIMER_W-1:0] QUAL_CYCLES      = compressor_remote_pkg::QUAL_CYCLES,
    parameter logic [compressor_remote_pkg::TIMER_W-1:0] ALARM_ON_CYCLES  = compressor_remote_pkg::ALARM_ON_CYCLES,
    parameter logic [compressor_remote_pkg::TIMER_W-1:0] ALARM_OFF_CYCLES = compressor_remote_pkg::ALARM_OFF_CYCLES,
    parameter logic [compressor_remote_pkg::TIMER_W-1:0] RIDE_CYCLES      = compressor_remote_pkg::RIDE_CYCLES
) (
    input  wire logic                         i_clk,
    input  wire logic                         i_nrst,
    input  wire compressor_remote_pkg::cmd_t  i_cmd,
    input  wire logic                         i_reset_button,
    input  wire logic                         i_mains_ok,
    input  wire logic                         i_fault,
    output var  compressor_remote_pkg::answer_t o_answer,
    output var  compressor_remote_pkg::mode_t o_mode
);

    import compressor_remote_pkg::*;

    // synchronised pins
    logic [SYNC_W-1:0] pins_sync;
    cmd_t              cmd;
    logic              button;
    logic              mains;

    // command, button and mains pins share one synchroniser, so their
    // relative timing is kept to within one cycle
    pin_sync #(
        .WIDTH (SYNC_W)
    ) u_pin_sync (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_async ({i_cmd, i_reset_button, i_mains_ok}),
        .o_sync  (pins_sync)
    );

    // every remote pin passes the synchroniser before use
    assign cmd    = cmd_t'(pins_sync[SYNC_W-1:2]);
    assign button = pins_sync[1];
    assign mains  = pins_sync[0];

    // ------------------------------------------------------------------
    // power sequencing: init window, running, short dip, switched off
    // ------------------------------------------------------------------
    power_t             power;
    power_t             next_power;
    logic [TIMER_W-1:0] ptimer;
    logic [TIMER_W-1:0] next_ptimer;
    logic               inputs_live;

    // the timer saturates instead of wrapping, so a very long
    // switch-off can never sound the off alarm again or hold back the restart on mains return;
    // a dip that outlasts the ride-through window is handled
    // exactly like a switch-off, off alarm included
    // limitation: no settle delay before restart after a dip
    always_comb begin
        next_power  = power;
        next_ptimer = (ptimer == {TIMER_W{1'b1}}) ? ptimer : ptimer + 1'b1;
        case (power)
            PWR_INIT: begin
                // unit stays deaf to commands and runs nothing until initialisation ends
                if (ptimer >= INIT_CYCLES - 1'b1) begin
                    next_power  = PWR_UP;
                    next_ptimer = TIMER_RST;
                end
            end
            PWR_UP: begin
                next_ptimer = TIMER_RST;
                if (!mains) begin
                    next_power = PWR_DIP;
                end
            end
            PWR_DIP: begin
                // ride-through: a short loss keeps the latched run state
                if (mains) begin
                    next_power  = PWR_UP;
                    next_ptimer = TIMER_RST;
                end else if (ptimer >= RIDE_CYCLES - 1'b1) begin
                    next_power  = PWR_OFF;
                    next_ptimer = TIMER_RST;
                end
            end
            PWR_OFF: begin
                // power back after a real switch-off is a fresh power-up
                if (mains && ptimer >= ALARM_OFF_CYCLES) begin
                    next_power  = PWR_INIT;
                    next_ptimer = TIMER_RST;
                end
            end
            default: begin
                next_power  = PWR_INIT;
                next_ptimer = TIMER_RST;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            power  <= PWR_INIT;
            ptimer <= TIMER_RST;
        end else begin
            power  <= next_power;
            ptimer <= next_ptimer;
        end
    end

    assign inputs_live = (power == PWR_UP);

    // ------------------------------------------------------------------
    // operating mode: fixed by the first compressor command after power-up
    // ------------------------------------------------------------------
    mode_t mode;
    mode_t next_mode;

    // the pick is only armed while inputs are live, so a pin already
    // high during initialisation decides the mode at the first live
    // cycle instead of being lost; a switch-off forgets the mode so
    // the next power-up picks again
    always_comb begin
        next_mode = mode;
        if (power == PWR_OFF) begin
            next_mode = MODE_NONE;
        end else if (inputs_live && mode == MODE_NONE) begin
            // a start pulse wins a tie; both at once breaks the controller's side anyway
            if (cmd.start_pulse) begin
                next_mode = MODE_PULSE;
            end else if (cmd.level_on) begin
                next_mode = MODE_LEVEL;
            end
        end
        // once chosen the mode is never re-evaluated while powered
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            mode <= MODE_NONE;
        end else begin
            mode <= next_mode;
        end
    end

    // ------------------------------------------------------------------
    // pulse mode start/stop qualification and run latch
    // ------------------------------------------------------------------
    logic [TIMER_W-1:0] start_cnt;
    logic [TIMER_W-1:0] next_start_cnt;
    logic [TIMER_W-1:0] stop_cnt;
    logic [TIMER_W-1:0] next_stop_cnt;
    logic               start_armed;
    logic               next_start_armed;
    logic               run_latch;
    logic               next_run_latch;
    logic               pulse_live;
    logic               start_qual;
    logic               stop_qual;

    assign pulse_live = inputs_live && (mode == MODE_PULSE);
    // counters saturate at the threshold; one more held cycle means longer than it
    assign start_qual = pulse_live && cmd.start_pulse && (start_cnt == QUAL_CYCLES);
    assign stop_qual  = pulse_live && !cmd.stop_hold && (stop_cnt == QUAL_CYCLES);

    // a start is only acted on at its release, so a start pin that
    // sticks high can never restart the pump behind a stop;
    // the price is a few cycles more answer-back delay, well
    // inside the allowed answer-back time
    always_comb begin
        next_start_cnt   = TIMER_RST;
        next_stop_cnt    = TIMER_RST;
        next_start_armed = start_armed;
        next_run_latch   = run_latch;
        if (pulse_live) begin
            // durations measured in clock cycles
            if (cmd.start_pulse) begin
                next_start_cnt = (start_cnt == QUAL_CYCLES) ? start_cnt : start_cnt + 1'b1;
            end
            if (!cmd.stop_hold) begin
                next_stop_cnt = (stop_cnt == QUAL_CYCLES) ? stop_cnt : stop_cnt + 1'b1;
            end
            if (stop_qual) begin
                // stop has priority over any pending start
                next_run_latch   = 1'b0;
                next_start_armed = 1'b0;
            end else if (start_qual) begin
                next_start_armed = 1'b1;
            end else if (start_armed && !cmd.start_pulse) begin
                next_run_latch   = 1'b1;
                next_start_armed = 1'b0;
            end
        end else begin
            next_start_armed = 1'b0;
            // the run latch survives a short dip but not a switch-off
            if (power == PWR_OFF || mode != MODE_PULSE) begin
                next_run_latch = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            start_cnt   <= TIMER_RST;
            stop_cnt    <= TIMER_RST;
            start_armed <= 1'b0;
            run_latch   <= 1'b0;
        end else begin
            start_cnt   <= next_start_cnt;
            stop_cnt    <= next_stop_cnt;
            start_armed <= next_start_armed;
            run_latch   <= next_run_latch;
        end
    end

    // ------------------------------------------------------------------
    // pump and refrigerator run decisions
    // ------------------------------------------------------------------
    logic pump_run;
    logic refrig1_run;
    logic refrig2_run;

    // refrigerator commands are pure levels; pacing of refrigerator
    // starts and stops is left to the controller, nothing here
    // rate-limits them
    always_comb begin
        pump_run = 1'b0;
        if (inputs_live) begin
            case (mode)
                MODE_PULSE: pump_run = run_latch;
                MODE_LEVEL: pump_run = cmd.level_on;
                default:    pump_run = 1'b0;
            endcase
        end
        // refrigerators only run behind a running pump
        refrig1_run = pump_run && cmd.refrig1_cmd;
        refrig2_run = pump_run && cmd.refrig2_cmd;
    end

    // ------------------------------------------------------------------
    // alarm latch: fault sets, front-panel reset clears once fault is gone
    // ------------------------------------------------------------------
    logic alarm_latch;
    logic next_alarm_latch;
    logic power_alarm;

    // i_fault is already on i_clk and needs no synchroniser; a fault
    // in the same cycle as a button press keeps the alarm set, so a
    // held button can never hide a live fault
    always_comb begin
        next_alarm_latch = alarm_latch;
        if (i_fault) begin
            next_alarm_latch = 1'b1;
        end else if (button) begin
            next_alarm_latch = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            alarm_latch <= 1'b0;
        end else begin
            alarm_latch <= next_alarm_latch;
        end
    end

    // short alarm pulses mark power-up and switch-off
    assign power_alarm = ((power == PWR_INIT) && (ptimer < ALARM_ON_CYCLES)) ||
                         ((power == PWR_OFF) && (ptimer < ALARM_OFF_CYCLES));

    // ------------------------------------------------------------------
    // answer-back contacts, registered; one cycle behind the decision
    // ------------------------------------------------------------------
    answer_t next_answer;

    // every contact is registered so combinational glitches never
    // reach the contact drivers; the alarm contact therefore shows a
    // fault two edges after i_fault rises
    always_comb begin
        next_answer             = ANSWER_RST;
        next_answer.comp_run    = pump_run;
        next_answer.refrig1_ack = refrig1_run;
        next_answer.refrig2_ack = refrig2_run;
        // fault alarm is held through init too, so a latched fault is never hidden
        next_answer.alarm       = alarm_latch || power_alarm;
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_answer <= ANSWER_RST;
            o_mode   <= MODE_NONE;
        end else begin
            o_answer <= next_answer;
            o_mode   <= mode;
        end
    end

endmodule : compressor_remote_control

`default_nettype wire

// ### logic/compressor_remote_pkg.sv
// constants, carriers and enumerations for the compressor remote control logic
// assumes one 25 MHz clock and a synchronous active-low reset from power-on
package compressor_remote_pkg;

    localparam int unsigned CLK_HZ      = 25_000_000;
    localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
    localparam int unsigned TIMER_W     = 28;
    localparam int unsigned SYNC_STAGES = 2;

    // times as printed, in milliseconds
    localparam int unsigned INIT_MS      = 5000;
    localparam int unsigned QUAL_MS      = 300;
    localparam int unsigned ALARM_ON_MS  = 500;
    localparam int unsigned ALARM_OFF_MS = 2000;
    localparam int unsigned RIDE_MS      = 2000;

    // cycle counts derived from the times (all exact at 25 MHz)
    localparam logic [TIMER_W-1:0] INIT_CYCLES      = TIMER_W'(INIT_MS * CYC_PER_MS);
    localparam logic [TIMER_W-1:0] QUAL_CYCLES      = TIMER_W'(QUAL_MS * CYC_PER_MS);
    localparam logic [TIMER_W-1:0] ALARM_ON_CYCLES  = TIMER_W'(ALARM_ON_MS * CYC_PER_MS);
    localparam logic [TIMER_W-1:0] ALARM_OFF_CYCLES = TIMER_W'(ALARM_OFF_MS * CYC_PER_MS);
    localparam logic [TIMER_W-1:0] RIDE_CYCLES      = TIMER_W'(RIDE_MS * CYC_PER_MS);

    // remote command pins, already level-shifted to logic, high = on
    typedef struct packed {
        logic start_pulse;
        logic stop_hold;
        logic level_on;
        logic refrig1_cmd;
        logic refrig2_cmd;
    } cmd_t;

    // answer-back contacts, high = contact closed
    typedef struct packed {
        logic comp_run;
        logic alarm;
        logic refrig1_ack;
        logic refrig2_ack;
    } answer_t;

    localparam int unsigned SYNC_W = $bits(cmd_t) + 2;
    localparam answer_t ANSWER_RST = '0;
    localparam logic [TIMER_W-1:0] TIMER_RST = '0;

    typedef enum logic [1:0] {
        MODE_NONE,
        MODE_PULSE,
        MODE_LEVEL
    } mode_t;

    typedef enum logic [1:0] {
        PWR_INIT,
        PWR_UP,
        PWR_DIP,
        PWR_OFF
    } power_t;

endpackage : compressor_remote_pkg

// ### logic/pin_sync.sv
// two flip-flop synchroniser, one chain per bit
// assumes inputs are asynchronous pins; output is safe for logic on i_clk
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    input  wire logic [WIDTH-1:0] i_async,
    output var  logic [WIDTH-1:0] o_sync
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic meta;
            logic settled;
            // first stage feeds only the second stage
            always_ff @(posedge i_clk) begin
                if (!i_nrst) begin
                    meta    <= 1'b0;
                    settled <= 1'b0;
                end else begin
                    meta    <= i_async[g];
                    settled <= meta;
                end
            end
            // each bit has its own process, so the output is joined here
            assign o_sync[g] = settled;
        end
    endgenerate

endmodule : pin_sync

`default_nettype wire

// ### testbench/equip_controller.sv
// equipment-side controller driving the remote command pins
// assumes the bench calls its tasks; pins move 1 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none

module equip_controller (
    input  wire logic                        i_clk,
    output var  compressor_remote_pkg::cmd_t o_cmd
);
    import compressor_remote_pkg::*;

    // idle: stop-hold kept high, every other pin open
    initial o_cmd = '{stop_hold: 1'b1, default: 1'b0};

    task automatic hold(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : hold

    // start pulse; stop-hold stays high meanwhile
    task automatic pulse_start(input int n);
        o_cmd.start_pulse = 1'b1;
        hold(n);
        o_cmd.start_pulse = 1'b0;
    endtask : pulse_start

    // stop-hold dropped only while start is already low
    task automatic pulse_stop(input int n);
        o_cmd.stop_hold = 1'b0;
        hold(n);
        o_cmd.stop_hold = 1'b1;
    endtask : pulse_stop

    // level pin and refrigerator pins; one mode per power cycle
    task automatic level(input logic v, input logic a, input logic b);
        o_cmd.level_on    = v;
        o_cmd.refrig1_cmd = a;
        o_cmd.refrig2_cmd = b;
    endtask : level
endmodule : equip_controller
`default_nettype wire

// ### testbench/remote_sva.sv
// port checker for the compressor remote control
// assumes one clock domain; bound onto the control module below
`timescale 1ns/1ps
`default_nettype none

module remote_sva #(
    parameter int INIT_CYC = 200,
    parameter int QUAL_CYC = 20,
    parameter int ALON_CYC = 30
) (
    input wire logic                            i_clk,
    input wire logic                            i_nrst,
    input wire compressor_remote_pkg::cmd_t     i_cmd,
    input wire logic                            i_reset_button,
    input wire logic                            i_mains_ok,
    input wire logic                            i_fault,
    input wire compressor_remote_pkg::answer_t  o_answer,
    input wire compressor_remote_pkg::mode_t    o_mode
);
    import compressor_remote_pkg::*;
    default clocking dclk @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    int up_cnt, next_up_cnt, low_cnt, next_low_cnt;

    // age since reset and stop-hold low time; capped so they never wrap
    always_comb begin
        next_up_cnt  = !i_nrst ? 0 : (up_cnt < 60000) ? up_cnt + 1 : up_cnt;
        next_low_cnt = (!i_nrst || i_cmd.stop_hold) ? 0 : (low_cnt < 60000) ? low_cnt + 1 : low_cnt;
    end
    always_ff @(posedge i_clk) begin
        up_cnt  <= next_up_cnt;
        low_cnt <= next_low_cnt;
    end

    ack_needs_run_a: assert property ((o_answer.refrig1_ack || o_answer.refrig2_ack) |-> o_answer.comp_run)
        else $error("ack without pump");
    mode_kept_a: assert property (o_mode != MODE_NONE |=> o_mode == $past(o_mode) || o_mode == MODE_NONE)
        else $error("mode switched");
    level_run_a: assert property ($rose(i_cmd.level_on) && o_mode == MODE_LEVEL ##1 i_mains_ok [*4]
        |-> o_answer.comp_run) else $error("pump not started");
    level_stop_a: assert property ($fell(i_cmd.level_on) && o_mode == MODE_LEVEL |-> ##4 !o_answer.comp_run)
        else $error("pump not stopped");
    // latch on the first edge, contact register on the second
    fault_alarm_a: assert property (i_fault |-> ##2 o_answer.alarm)
        else $error("fault without alarm");
    alarm_latch_a: assert property ((!i_reset_button) [*3] ##0 i_fault ##1 (!i_reset_button) [*3]
        |-> o_answer.alarm) else $error("alarm cleared unpressed");
    stop_latch_a: assert property (o_mode == MODE_PULSE && low_cnt > QUAL_CYC + 5
        |-> !o_answer.comp_run && !o_answer.refrig1_ack) else $error("stop ignored");
    init_quiet_a: assert property (up_cnt < INIT_CYC |-> o_mode == MODE_NONE && !o_answer.comp_run)
        else $error("active during init");
    power_alarm_a: assert property (up_cnt >= 1 && up_cnt < ALON_CYC |-> o_answer.alarm)
        else $error("no power-up alarm");
    ack_follow_a: assert property (i_cmd.refrig1_cmd [*4] ##0 o_answer.comp_run [*3]
        |-> o_answer.refrig1_ack) else $error("ack late");
    ack_drop_a: assert property ((!i_cmd.refrig2_cmd) [*4] |-> !o_answer.refrig2_ack)
        else $error("ack stuck");
endmodule : remote_sva

bind compressor_remote_control remote_sva #(
    .INIT_CYC(INIT_CYCLES), .QUAL_CYC(QUAL_CYCLES), .ALON_CYC(ALARM_ON_CYCLES)
) chk (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_cmd(i_cmd), .i_reset_button(i_reset_button),
    .i_mains_ok(i_mains_ok), .i_fault(i_fault), .o_answer(o_answer), .o_mode(o_mode)
);
`default_nettype wire

// ### testbench/test_compressor_remote_control.sv
// self-checking bench for the compressor remote control
// assumes the package and the equip_controller partner; small counts keep it short
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
    $display("wrong value at %0t: got %h want %h", $time, a, e); end end

module test_compressor_remote_control;
    import compressor_remote_pkg::*;
    localparam int INIT = 200, QUAL = 20, ALON = 30, ALOFF = 40, RIDE = 50;
    logic        i_clk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        i_reset_button = 1'b0;
    logic        i_mains_ok = 1'b1;
    logic        i_fault = 1'b0;
    cmd_t        i_cmd;
    answer_t     o_answer;
    mode_t       o_mode;
    int          bad_count = 0, compares = 0, run = 0, r1 = 0, r2 = 0;
    int unsigned seed = 18581;

    always #20 i_clk = ~i_clk;

    equip_controller ctrl (.i_clk(i_clk), .o_cmd(i_cmd));
    compressor_remote_control #(
        .INIT_CYCLES(TIMER_W'(INIT)), .QUAL_CYCLES(TIMER_W'(QUAL)), .ALARM_ON_CYCLES(TIMER_W'(ALON)),
        .ALARM_OFF_CYCLES(TIMER_W'(ALOFF)), .RIDE_CYCLES(TIMER_W'(RIDE))
    ) dut (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_cmd(i_cmd), .i_reset_button(i_reset_button),
        .i_mains_ok(i_mains_ok), .i_fault(i_fault), .o_answer(o_answer), .o_mode(o_mode)
    );

    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step

    // expected contacts from the bench's own pump and command state
    task automatic check_ans(input logic al);
        answer_t e;
        e = '{run != 0, al, run != 0 && r1 != 0, run != 0 && r2 != 0};
        `CHK(o_answer, e)
    endtask : check_ans

    task automatic give_verdict();
        $display("mismatches %0d, compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    // bounded wait; running out counts as a mismatch and ends the run
    task automatic wait_mode(input mode_t m);
        for (int i = 0; i < 400 && o_mode !== m; i++) step(1);
        if (o_mode !== m) begin
            bad_count++;
            $display("wrong value at %0t: mode wait ran out", $time);
            give_verdict();
        end
    endtask : wait_mode

    initial begin
        step(12);
        i_nrst = 1'b1;
        ctrl.level(1'b1, 1'b0, 1'b0); // level raised during init must wait
        step(5);
        check_ans(1'b1);
        step(INIT - 20);
        check_ans(1'b0);
        wait_mode(MODE_LEVEL);
        run = 1;
        step(4);
        check_ans(1'b0);
        repeat (6) begin
            r1 = xs() & 1;
            r2 = xs() & 1;
            ctrl.level(1'b1, r1[0], r2[0]);
            step(5);
            check_ans(1'b0);
        end
        ctrl.pulse_start(QUAL + 5); // wrong-mode pin, refused
        `CHK(o_mode, MODE_LEVEL)
        r1 = 1;
        r2 = 1;
        ctrl.level(1'b0, 1'b1, 1'b1);
        run = 0;
        step(5);
        check_ans(1'b0);
        ctrl.level(1'b1, 1'b1, 1'b1);
        run = 1;
        step(5);
        check_ans(1'b0);
        // fault latch: held with button up, held while fault stays, then cleared
        i_fault = 1'b1;
        step(1);
        i_fault = 1'b0;
        step(4);
        check_ans(1'b1);
        i_fault = 1'b1;
        i_reset_button = 1'b1;
        step(6);
        check_ans(1'b1);
        i_fault = 1'b0;
        step(6);
        check_ans(1'b0);
        i_reset_button = 1'b0;
        // short dip in level mode: quiet, then follows the level pin again
        i_mains_ok = 1'b0;
        step(RIDE / 2);
        run = 0;
        check_ans(1'b0);
        i_mains_ok = 1'b1;
        run = 1;
        step(8);
        check_ans(1'b0);
        // switch-off: off alarm, then a fresh power-up with the mode cleared
        ctrl.level(1'b0, 1'b1, 1'b1);
        i_mains_ok = 1'b0;
        run = 0;
        step(RIDE + 15);
        check_ans(1'b1);
        step(ALOFF + 20);
        check_ans(1'b0);
        i_mains_ok = 1'b1;
        step(5);
        check_ans(1'b1);
        `CHK(o_mode, MODE_NONE)
        step(INIT);
        ctrl.pulse_start(QUAL / 2); // too short to start
        step(6);
        check_ans(1'b0);
        `CHK(o_mode, MODE_PULSE)
        ctrl.pulse_start(QUAL + 5);
        run = 1;
        step(6);
        check_ans(1'b0);
        ctrl.pulse_stop(QUAL - 5); // too short to stop
        step(6);
        check_ans(1'b0);
        i_mains_ok = 1'b0;
        step(20);
        i_mains_ok = 1'b1;
        step(8);
        check_ans(1'b0);
        // held well past the threshold so the checker sees the latched stop
        ctrl.pulse_stop(QUAL + 10);
        run = 0;
        step(10);
        check_ans(1'b0);
        ctrl.pulse_start(QUAL + 2); // restart right after the stop
        run = 1;
        step(6);
        check_ans(1'b0);
        give_verdict();
    end
endmodule : test_compressor_remote_control
`default_nettype wire
